// ==== hw/hdt_config.sv ====
// Haptic drive timing configuration registers and decoded controls
`timescale 1ns/1ns
module hdt_config
  import hdt_pkg::*;
#(
  parameter int CLK_PERIOD_NS = HDT_CLK_PERIOD_NS
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port behind the serial host bus
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // Drive engine status inputs
  input wire logic actuator_type_select,
  input wire logic [2:0] op_mode,
  input wire logic cycle_start,
  // Dissipation timing
  output logic [12:0] dissip_cycles_q,
  output logic gap_active_q,
  // Decoded controls
  output logic noise_gate_en_q,
  output logic [3:0] noise_gate_pct_q,
  output logic rm_closed_loop_q,
  output logic lr_closed_loop_q,
  output logic supply_comp_en_q,
  output logic rtp_unsigned_q,
  output logic amp_twice_per_cycle_q,
  output logic trig_pwm_in_q,
  output logic trig_analog_in_q
);

  //----------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------
  logic [7:0] cfg_two_q; // Second control register
  logic [7:0] cfg_three_q; // Third control register
  logic [7:0] cfg_ext_q; // Holds upper dissipation bits
  logic [3:0] diss_code; // Full dissipation code
  logic [12:0] dissip_d; // Looked-up gap length
  logic gap_busy; // Timer running

  // Register writes; unmapped addresses are ignored
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg_two_q <= HDT_RST_CFG_TWO;
      cfg_three_q <= HDT_RST_CFG_THREE;
      cfg_ext_q <= HDT_RST_CFG_EXT;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        HDT_ADDR_CFG_TWO: cfg_two_q <= reg_wdata;
        HDT_ADDR_CFG_THREE: cfg_three_q <= reg_wdata;
        HDT_ADDR_CFG_EXT: cfg_ext_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd)
      begin
        unique case (reg_addr)
          HDT_ADDR_CFG_TWO: reg_rdata_q <= cfg_two_q;
          HDT_ADDR_CFG_THREE: reg_rdata_q <= cfg_three_q;
          HDT_ADDR_CFG_EXT: reg_rdata_q <= cfg_ext_q;
          default: reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  //----------------------------------------------------------------
  // Dissipation lookup
  //----------------------------------------------------------------
  // Upper two bits only count for the resonant actuator
  assign diss_code = {cfg_ext_q[1:0], cfg_two_q[1:0]};

  // Table picked from the live type select
  always_comb
  begin
    if (actuator_type_select)
    begin
      dissip_d = hdt_us_to_cyc(HDT_LR_US[diss_code],
        CLK_PERIOD_NS);
    end
    else
    begin
      dissip_d = hdt_us_to_cyc(HDT_RM_US[cfg_two_q[1:0]],
        CLK_PERIOD_NS);
    end
  end

  // Latched only at a cycle start so a mode flip waits a cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dissip_cycles_q <= hdt_us_to_cyc(HDT_RM_US[2], CLK_PERIOD_NS);
    end
    else if (cycle_start)
    begin
      dissip_cycles_q <= dissip_d;
    end
  end

  // Gap timer loads the looked-up length at each cycle start
  hdt_gap_timer #(
    .W(13)
  ) u_hdt_gap_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(cycle_start),
    .load_val(dissip_d),
    .busy_q(gap_busy)
  );

  // Registered copy keeps the output straight from a flop
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      gap_active_q <= 1'b0;
    end
    else
    begin
      gap_active_q <= gap_busy;
    end
  end

  //----------------------------------------------------------------
  // Decoded controls
  //----------------------------------------------------------------
  // Noise gate only makes sense for pulse-width or analog input
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      noise_gate_en_q <= 1'b0;
      noise_gate_pct_q <= 4'h0;
    end
    else
    begin
      noise_gate_en_q <= (cfg_three_q[HDT_NG_LSB+:2] != 2'h0) &&
        (op_mode == HDT_MODE_SIG_IN);
      unique case (cfg_three_q[HDT_NG_LSB+:2])
        2'h0: noise_gate_pct_q <= 4'h0;
        2'h1: noise_gate_pct_q <= 4'h2;
        2'h2: noise_gate_pct_q <= 4'h4;
        2'h3: noise_gate_pct_q <= 4'h8;
      endcase
    end
  end

  // Loop, compensation, format and update rate selects
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rm_closed_loop_q <= 1'b0;
      lr_closed_loop_q <= 1'b0;
      supply_comp_en_q <= 1'b1;
      rtp_unsigned_q <= 1'b0;
      amp_twice_per_cycle_q <= 1'b0;
    end
    else
    begin
      rm_closed_loop_q <= !actuator_type_select &&
        !cfg_three_q[HDT_RM_OL_BIT];
      lr_closed_loop_q <= actuator_type_select &&
        !cfg_three_q[HDT_LR_OL_BIT];
      supply_comp_en_q <= !cfg_three_q[HDT_SUP_DIS_BIT];
      rtp_unsigned_q <= cfg_three_q[HDT_RTP_FMT_BIT];
      amp_twice_per_cycle_q <= cfg_three_q[HDT_UPD_RATE_BIT];
    end
  end

  // Trigger pin routing in signal-input mode
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      trig_pwm_in_q <= 1'b0;
      trig_analog_in_q <= 1'b0;
    end
    else
    begin
      trig_pwm_in_q <= (op_mode == HDT_MODE_SIG_IN) &&
        !cfg_three_q[HDT_IN_KIND_BIT];
      trig_analog_in_q <= (op_mode == HDT_MODE_SIG_IN) &&
        cfg_three_q[HDT_IN_KIND_BIT];
    end
  end

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_start;
    cycle_start;
  endsequence

  a_three_reset: assert property ($past(rst) |-> cfg_three_q == 8'hA0)
    else $error("third control register reset value wrong");
  a_two_reset: assert property ($past(rst) |-> cfg_two_q[1:0] == 2'h2)
    else $error("dissipation field reset value wrong");
  a_three_write: assert property (reg_wr && reg_addr == 8'h1D |=>
    cfg_three_q == $past(reg_wdata))
    else $error("third control register write lost");
  a_rm_lookup: assert property (s_start and !actuator_type_select |=>
    dissip_cycles_q == hdt_us_to_cyc(HDT_RM_US[$past(cfg_two_q[1:0])],
    CLK_PERIOD_NS))
    else $error("rotating-mass dissipation time wrong");
  a_lr_lookup: assert property (s_start and actuator_type_select |=>
    dissip_cycles_q == hdt_us_to_cyc(HDT_LR_US[$past(diss_code)],
    CLK_PERIOD_NS))
    else $error("resonant dissipation time wrong");
  a_hold_between: assert property (!cycle_start |=>
    $stable(dissip_cycles_q))
    else $error("dissipation length changed outside a cycle start");
  a_gap_opens: assert property (s_start ##1 !cycle_start |=>
    gap_active_q)
    else $error("gap did not open after cycle start");
  a_ng_code: assert property (cfg_three_q[7:6] == 2'h3 |=>
    noise_gate_pct_q == 4'h8)
    else $error("noise gate percent wrong");
  a_rm_loop: assert property (!actuator_type_select &&
    !cfg_three_q[5] |=> rm_closed_loop_q)
    else $error("closed loop not selected");
  a_upd_rate: assert property (##1 amp_twice_per_cycle_q ==
    $past(cfg_three_q[2]))
    else $error("update rate does not follow register");
  a_trig_kind: assert property (op_mode == 3'h3 &&
    cfg_three_q[1] |=> trig_analog_in_q && !trig_pwm_in_q)
    else $error("trigger input kind wrong");

endmodule : hdt_config

// ==== hw/hdt_pkg.sv ====
// Package: register map, reset values and dissipation time tables
//------------------------------------------------------------------
// Function
// - Two-bit dissipation field, bits 1-0, resets 2
// - Resonant mode code adds two upper bits
// - Rotating-mass codes give 45 to 225 us
// - Resonant codes give 15 to 285 us
// - Third control register at 0x1D, fields listed
// - Third control register resets to bits 7, 5
// - Noise gate code: off, 2, 4, 8 percent
// - Open loop bit: 0 closed loop, 1 open
// - Update rate bit: once or twice per cycle
// - Mode 3: input kind pulse-width or analog
//------------------------------------------------------------------
package hdt_pkg;

  // Register addresses
  localparam logic [7:0] HDT_ADDR_CFG_TWO = 8'h1C;
  localparam logic [7:0] HDT_ADDR_CFG_THREE = 8'h1D;
  localparam logic [7:0] HDT_ADDR_CFG_EXT = 8'h1F;

  // Reset values
  localparam logic [7:0] HDT_RST_CFG_TWO = 8'h02;
  localparam logic [7:0] HDT_RST_CFG_THREE = 8'hA0;
  localparam logic [7:0] HDT_RST_CFG_EXT = 8'h00;

  // Field positions in the third control register
  localparam int HDT_NG_LSB = 6;
  localparam int HDT_RM_OL_BIT = 5;
  localparam int HDT_SUP_DIS_BIT = 4;
  localparam int HDT_RTP_FMT_BIT = 3;
  localparam int HDT_UPD_RATE_BIT = 2;
  localparam int HDT_IN_KIND_BIT = 1;
  localparam int HDT_LR_OL_BIT = 0;

  // Operating mode code that routes the trigger pin as a signal input
  localparam logic [2:0] HDT_MODE_SIG_IN = 3'h3;

  // Clock period in ns and width of the gap counter
  localparam int HDT_CLK_PERIOD_NS = 50;
  localparam int HDT_GAP_W = 13;

  // Dissipation times in microseconds
  localparam int HDT_RM_US [4] = '{45, 75, 150, 225};
  localparam int HDT_LR_US [16] = '{15, 25, 50, 75, 90, 105, 120, 135,
    150, 165, 180, 195, 210, 235, 260, 285};

  // Time to cycles, rounded up, never below one cycle
  function automatic logic [12:0] hdt_us_to_cyc(input int us,
    input int period_ns);
    int cyc;
    cyc = (us * 1000 + period_ns - 1) / period_ns;
    if (cyc < 1)
    begin
      cyc = 1;
    end
    return cyc[12:0];
  endfunction : hdt_us_to_cyc

endpackage : hdt_pkg

// ==== hw/hdt_gap_timer.sv ====
// Down-counter that holds the inter-cycle current decay gap
`timescale 1ns/1ns
module hdt_gap_timer
  import hdt_pkg::*;
#(
  parameter int W = HDT_GAP_W
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Status
  output logic busy_q
);

  logic [W-1:0] cnt_q; // Cycles left in the gap

  //----------------------------------------------------------------
  // Counter
  //----------------------------------------------------------------
  // A new load restarts the gap even mid-count
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end
    else if (load)
    begin
      cnt_q <= load_val;
      busy_q <= (load_val != '0);
    end
    else if (cnt_q != '0)
    begin
      cnt_q <= cnt_q - 1'b1;
      busy_q <= (cnt_q != {{(W-1){1'b0}}, 1'b1});
    end
  end

endmodule : hdt_gap_timer

// ==== test/haptic_drive_timing_config_tb.sv ====
// Self-checking bench for the drive timing configuration block
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module haptic_drive_timing_config_tb
  import hdt_pkg::*;
;
  //----------------------------------------------------------------
  // Signals
  //----------------------------------------------------------------
  // Slow period keeps the gaps short; all counts derive from it
  localparam int P = 5000;
  typedef struct packed {logic [7:0] d; logic [2:0] m; logic t;
    logic [11:0] e;} hdt_row_type;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic actuator_type_select = 1'b0;
  logic cycle_start = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [2:0] op_mode = 3'h0;
  logic [7:0] reg_rdata_q;
  logic reg_rvalid_q;
  logic [12:0] dissip_cycles_q;
  logic gap_active_q;
  logic noise_gate_en_q;
  logic [3:0] noise_gate_pct_q;
  logic rm_closed_loop_q;
  logic lr_closed_loop_q;
  logic supply_comp_en_q;
  logic rtp_unsigned_q;
  logic amp_twice_per_cycle_q;
  logic trig_pwm_in_q;
  logic trig_analog_in_q;
  logic [7:0] rdv;
  // Decoded outputs packed in the order of the row table
  logic [11:0] dec;
  assign dec = {noise_gate_en_q, noise_gate_pct_q, rm_closed_loop_q,
    lr_closed_loop_q, supply_comp_en_q, rtp_unsigned_q,
    amp_twice_per_cycle_q, trig_pwm_in_q, trig_analog_in_q};
  int n_errors = 0;
  int checks_done = 0;
  // Gap times in microseconds, kept apart from the design tables
  int rm_us [4] = '{45, 75, 150, 225};
  int lr_us [16] = '{15, 25, 50, 75, 90, 105, 120, 135, 150, 165,
    180, 195, 210, 235, 260, 285};
  // Rows: written field value, mode, type, packed decoded outputs
  hdt_row_type rows [4] = '{'{8'h00, 3'h3, 1'b0, 12'h052},
    '{8'h5E, 3'h3, 1'b0, 12'h94D}, '{8'hBB, 3'h3, 1'b1, 12'hA09},
    '{8'hE0, 3'h0, 1'b1, 12'h430}};

  always #25 ref_clk = ~ref_clk;

  hdt_config #(.CLK_PERIOD_NS(P)) u_hdt_config (.ref_clk(ref_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q),
    .actuator_type_select(actuator_type_select), .op_mode(op_mode),
    .cycle_start(cycle_start), .dissip_cycles_q(dissip_cycles_q),
    .gap_active_q(gap_active_q), .noise_gate_en_q(noise_gate_en_q),
    .noise_gate_pct_q(noise_gate_pct_q),
    .rm_closed_loop_q(rm_closed_loop_q),
    .lr_closed_loop_q(lr_closed_loop_q),
    .supply_comp_en_q(supply_comp_en_q),
    .rtp_unsigned_q(rtp_unsigned_q),
    .amp_twice_per_cycle_q(amp_twice_per_cycle_q),
    .trig_pwm_in_q(trig_pwm_in_q), .trig_analog_in_q(trig_analog_in_q));

  //----------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------
  // Rounded-up cycle count of a gap time
  function automatic logic [12:0] cyc(input int us);
    return 13'((us * 1000 + P - 1) / P);
  endfunction : cyc

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr

  // Bounded wait for the read answer; rdata holds after the pulse
  task automatic wait_rv(output logic [7:0] d);
    int k;
    k = 0;
    while (reg_rvalid_q !== 1'b1 && k < 4)
    begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 4)
    begin
      n_errors++;
      wrap_up();
    end
    d = reg_rdata_q;
  endtask : wait_rv

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    wait_rv(d);
    `CHK("read data", e, d)
    // Valid is a single-cycle pulse
    @(negedge ref_clk);
    `CHK("rvalid pulse", 1'b0, reg_rvalid_q)
  endtask : rd_chk

  // One drive cycle start, then the latched gap length
  task automatic start_chk(input logic [12:0] n);
    @(negedge ref_clk);
    cycle_start = 1'b1;
    @(negedge ref_clk);
    cycle_start = 1'b0;
    @(negedge ref_clk);
    `CHK("dissip cycles", n, dissip_cycles_q)
  endtask : start_chk

  // Gap must last about n cycles; one cycle of slack for the edges
  task automatic gap_chk(input logic [12:0] n);
    int cnt;
    int k;
    start_chk(n);
    cnt = 0;
    k = 0;
    while (gap_active_q !== 1'b1 && k < 4)
    begin
      @(negedge ref_clk);
      k++;
    end
    while (gap_active_q === 1'b1 && cnt < 400)
    begin
      @(negedge ref_clk);
      cnt++;
    end
    // A gap that never opens or never closes ends the run
    if (k == 4 || cnt == 400)
    begin
      n_errors++;
      wrap_up();
    end
    `CHK("gap length ok", 1'b1, (cnt >= n - 1 && cnt <= n + 1))
  endtask : gap_chk

  //----------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge ref_clk);
    `CHK("dissip reset", cyc(150), dissip_cycles_q)
    `CHK("decoded reset", 12'h010, dec)
    `CHK("gap reset", 1'b0, gap_active_q)
    `CHK("rvalid reset", 1'b0, reg_rvalid_q)
    rst = 1'b0;
    rd_chk(HDT_ADDR_CFG_TWO, 8'h02);
    rd_chk(HDT_ADDR_CFG_THREE, 8'hA0);
    rd_chk(HDT_ADDR_CFG_EXT, 8'h00);
    $display("test reset done");
    // Field decode rows; decoded outputs settle two cycles on
    foreach (rows[i])
    begin
      op_mode = rows[i].m;
      actuator_type_select = rows[i].t;
      wr(HDT_ADDR_CFG_THREE, rows[i].d);
      repeat (3) @(negedge ref_clk);
      `CHK("decoded", rows[i].e, dec)
      rd_chk(HDT_ADDR_CFG_THREE, rows[i].d);
    end
    $display("test fields done");
    // Every resonant code, upper bits from the extra register
    actuator_type_select = 1'b1;
    for (int c = 0; c < 16; c++)
    begin
      wr(HDT_ADDR_CFG_EXT, 8'(c >> 2));
      wr(HDT_ADDR_CFG_TWO, 8'(c & 3));
      start_chk(cyc(lr_us[c]));
    end
    $display("test resonant done");
    // Rotating-mass codes; upper bits left at 3 must be ignored
    actuator_type_select = 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      wr(HDT_ADDR_CFG_TWO, 8'(c) | 8'hFC);
      rd_chk(HDT_ADDR_CFG_TWO, 8'(c) | 8'hFC);
      start_chk(cyc(rm_us[c]));
    end
    gap_chk(cyc(225));
    $display("test rotating done");
    // Type change mid-cycle only counts from the next start
    start_chk(cyc(225));
    actuator_type_select = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK("dissip held", cyc(225), dissip_cycles_q)
    start_chk(cyc(285));
    $display("test mode change done");
    // Unmapped write is dropped, unmapped read gives zero
    wr(8'h10, 8'hFF);
    rd_chk(8'h10, 8'h00);
    rd_chk(HDT_ADDR_CFG_THREE, 8'hE0);
    // Read and write together: the read sees the old value
    @(negedge ref_clk);
    reg_addr = HDT_ADDR_CFG_THREE;
    reg_wdata = 8'h11;
    reg_wr = 1'b1;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    wait_rv(rdv);
    `CHK("old value", 8'hE0, rdv)
    rd_chk(HDT_ADDR_CFG_THREE, 8'h11);
    $display("test refused done");
    // Second reset in mid-run restores every register
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK("dissip reset", cyc(150), dissip_cycles_q)
    `CHK("decoded reset", 12'h010, dec)
    `CHK("gap reset", 1'b0, gap_active_q)
    rst = 1'b0;
    rd_chk(HDT_ADDR_CFG_TWO, 8'h02);
    rd_chk(HDT_ADDR_CFG_THREE, 8'hA0);
    rd_chk(HDT_ADDR_CFG_EXT, 8'h00);
    $display("test second reset done");
    wrap_up();
  end
endmodule : haptic_drive_timing_config_tb
